/* File: hdl/pgood_tree_params.svh */
`ifndef PGOOD_TREE_PARAMS_SVH
`define PGOOD_TREE_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PG_ADDR_W 8
`define PG_OFS_PIN3_MASK2 8'hab
`define PG_OFS_CTRL_MASKS 8'hac
`define PG_OFS_TERM_DISCH 8'had

// ----------------------------------------
// field positions
// ----------------------------------------
`define PG_BIT_CTRL_IN5 7
`define PG_BIT_CTRL_IN4 6
`define PG_BIT_CTRL_IN2 5
`define PG_BIT_CTRL_IN1 4
`define PG_BIT_TERM_REG 3
`define PG_BIT_SHARED 2
`define PG_BIT_SWITCH_B1 1
`define PG_BIT_LDO_A3 0
`define PG_BIT_DISCH_SEL 4

// ----------------------------------------
// default factory settings
// ----------------------------------------
`define PG_OTP_PIN3_MASK2 8'hff
`define PG_OTP_CTRL_MASKS 8'hff
`define PG_OTP_TERM_DISCH 8'h5f

`endif

/* File: hdl/pgood_tree_pkg.sv */
package pgood_tree_pkg;
  typedef logic [7:0] reg8_t;
  typedef enum logic {RAIL_SWITCH_B2, RAIL_LDO_A1} shared_rail_e;
endpackage : pgood_tree_pkg

/* File: hdl/pg_sync2.sv */
`timescale 1ns/100ps
module pg_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= async_in;
      stage2_ff <= stage1_ff;
    end
  end

  assign sync_out = stage2_ff;
endmodule : pg_sync2

/* File: hdl/pg_tree_and.sv */
`timescale 1ns/100ps
module pg_tree_and #(
  parameter int N = 8
) (
  input wire logic [N-1:0] good_in,
  input wire logic [N-1:0] mask_in,
  output logic tree_good_out
);
  logic [N-1:0] term;

  // masked source counts as good
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_term
      assign term[g] = mask_in[g] | good_in[g];
    end
  endgenerate

  assign tree_good_out = &term;
endmodule : pg_tree_and

/* File: hdl/pgood_tree_mask_regs.sv */
// What this block does
// - mask2 bits 7..4 mask control inputs 5,4,2,1 from pin-3 tree.
// - mask2 bits 3..0 mask termination, shared rail, switch B1, LDO A3.
// - mask 0 includes the source in pin-3 tree, 1 ignores it.
// - mask2 bit 2 covers switch B2 or LDO A1 per factory variant.
// - cross mask pairs for inputs 6/3: pin3 7/6, pin2 5/4, pin4 3/2, pin1 1/0.
// - cross mask 0 includes that input in the pin tree, 1 excludes.
// - discharge bit 4 set selects 100 ohm termination discharge path.
// - registers at ab, ac, ad, all read/write, reset from factory settings.
// - a rail power-good is 1 only while in regulation.
`timescale 1ns/100ps
`include "pgood_tree_params.svh"
module pgood_tree_mask_regs (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic [7:0] otp_pin3_mask2_in,
  input wire logic [7:0] otp_ctrl_masks_in,
  input wire logic [7:0] otp_term_disch_in,
  input wire logic otp_shared_is_ldo_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [6:1] ctrl_in_status_in,
  input wire logic termination_regulator_pg_in,
  input wire logic switch_b2_pg_in,
  input wire logic ldo_a1_a_pg_in,
  input wire logic switch_b1_pg_in,
  input wire logic ldo_a3_pg_in,
  input wire logic [4:1] pin_other_tree_good_in,
  output logic [4:1] pg_output_pin_out,
  output logic termination_discharge_sel_out
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [10:0] raw_status;
  logic [10:0] sync_status;
  logic [6:1] ctl_s;
  logic term_pg_s;
  logic switch_b2_pg_s;
  logic ldo_a1_a_pg_s;
  logic swb1_pg_s;
  logic ldoa3_pg_s;

  assign raw_status = {ldo_a3_pg_in, switch_b1_pg_in, ldo_a1_a_pg_in, switch_b2_pg_in,
                       termination_regulator_pg_in, ctrl_in_status_in};

  pg_sync2 #(.WIDTH(11)) u_sync (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .async_in(raw_status),
    .sync_out(sync_status)
  );

  assign ctl_s = sync_status[5:0];
  assign term_pg_s = sync_status[6];
  assign switch_b2_pg_s = sync_status[7];
  assign ldo_a1_a_pg_s = sync_status[8];
  assign swb1_pg_s = sync_status[9];
  assign ldoa3_pg_s = sync_status[10];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  pgood_tree_pkg::reg8_t pin3_tree_mask_second_ff;
  pgood_tree_pkg::reg8_t ctrl_input_tree_masks_ff;
  pgood_tree_pkg::reg8_t termination_discharge_cfg_ff;
  pgood_tree_pkg::shared_rail_e shared_rail_ff;

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pin3_tree_mask_second_ff <= otp_pin3_mask2_in;
    end else if (wr_in && addr_in == `PG_OFS_PIN3_MASK2) begin
      pin3_tree_mask_second_ff <= wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      ctrl_input_tree_masks_ff <= otp_ctrl_masks_in;
    end else if (wr_in && addr_in == `PG_OFS_CTRL_MASKS) begin
      ctrl_input_tree_masks_ff <= wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      termination_discharge_cfg_ff <= otp_term_disch_in;
    end else if (wr_in && addr_in == `PG_OFS_TERM_DISCH) begin
      termination_discharge_cfg_ff <= wdata_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      shared_rail_ff <= otp_shared_is_ldo_in ? pgood_tree_pkg::RAIL_LDO_A1 : pgood_tree_pkg::RAIL_SWITCH_B2;
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;

  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_in && addr_in == `PG_OFS_PIN3_MASK2) begin
      nxt_rdata = pin3_tree_mask_second_ff;
    end else if (rd_in && addr_in == `PG_OFS_CTRL_MASKS) begin
      nxt_rdata = ctrl_input_tree_masks_ff;
    end else if (rd_in && addr_in == `PG_OFS_TERM_DISCH) begin
      nxt_rdata = termination_discharge_cfg_ff;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_out = rdata_ff;

  // ----------------------------------------
  // pin-3 tree
  // ----------------------------------------
  logic ctrl_in5_mask;
  logic ctrl_in4_mask;
  logic ctrl_in2_mask;
  logic ctrl_in1_mask;
  logic termination_reg_mask;
  logic shared_rail_mask;
  logic switch_b1_mask;
  logic ldo_a3_mask;
  logic shared_pg;
  logic [9:0] p3_good;
  logic [9:0] p3_mask;
  logic p3_tree;

  assign ctrl_in5_mask = pin3_tree_mask_second_ff[`PG_BIT_CTRL_IN5];
  assign ctrl_in4_mask = pin3_tree_mask_second_ff[`PG_BIT_CTRL_IN4];
  assign ctrl_in2_mask = pin3_tree_mask_second_ff[`PG_BIT_CTRL_IN2];
  assign ctrl_in1_mask = pin3_tree_mask_second_ff[`PG_BIT_CTRL_IN1];
  assign termination_reg_mask = pin3_tree_mask_second_ff[`PG_BIT_TERM_REG];
  assign shared_rail_mask = pin3_tree_mask_second_ff[`PG_BIT_SHARED];
  assign switch_b1_mask = pin3_tree_mask_second_ff[`PG_BIT_SWITCH_B1];
  assign ldo_a3_mask = pin3_tree_mask_second_ff[`PG_BIT_LDO_A3];

  assign shared_pg = (shared_rail_ff == pgood_tree_pkg::RAIL_LDO_A1) ? ldo_a1_a_pg_s : switch_b2_pg_s;

  assign p3_good = {ctl_s[6], ctl_s[3], ctl_s[5], ctl_s[4], ctl_s[2], ctl_s[1],
                    term_pg_s, shared_pg, swb1_pg_s, ldoa3_pg_s};
  assign p3_mask = {ctrl_input_tree_masks_ff[7], ctrl_input_tree_masks_ff[6],
                    ctrl_in5_mask, ctrl_in4_mask, ctrl_in2_mask, ctrl_in1_mask,
                    termination_reg_mask, shared_rail_mask, switch_b1_mask, ldo_a3_mask};

  pg_tree_and #(.N(10)) u_p3 (
    .good_in(p3_good),
    .mask_in(p3_mask),
    .tree_good_out(p3_tree)
  );

  // ----------------------------------------
  // other pins
  // ----------------------------------------
  logic pin1_in6_mask;
  logic pin1_in3_mask;
  logic pin2_in6_mask;
  logic pin2_in3_mask;
  logic pin4_in6_mask;
  logic pin4_in3_mask;
  logic [4:1] nxt_pin;
  logic [4:1] pin_ff;

  assign pin1_in6_mask = ctrl_input_tree_masks_ff[1];
  assign pin1_in3_mask = ctrl_input_tree_masks_ff[0];
  assign pin4_in6_mask = ctrl_input_tree_masks_ff[3];
  assign pin4_in3_mask = ctrl_input_tree_masks_ff[2];
  assign pin2_in6_mask = ctrl_input_tree_masks_ff[5];
  assign pin2_in3_mask = ctrl_input_tree_masks_ff[4];

  always_comb begin
    nxt_pin[1] = (pin1_in6_mask | ctl_s[6]) & (pin1_in3_mask | ctl_s[3]) & pin_other_tree_good_in[1];
    nxt_pin[2] = (pin2_in6_mask | ctl_s[6]) & (pin2_in3_mask | ctl_s[3]) & pin_other_tree_good_in[2];
    nxt_pin[3] = p3_tree & pin_other_tree_good_in[3];
    nxt_pin[4] = (pin4_in6_mask | ctl_s[6]) & (pin4_in3_mask | ctl_s[3]) & pin_other_tree_good_in[4];
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      pin_ff <= 4'h0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign pg_output_pin_out = pin_ff;

  assign termination_discharge_sel_out = termination_discharge_cfg_ff[`PG_BIT_DISCH_SEL];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_WRITE_READ: assert property (@(posedge clock_in) disable iff (srst_in)
    wr_in && addr_in == `PG_OFS_CTRL_MASKS ##1 rd_in && addr_in == `PG_OFS_CTRL_MASKS && !wr_in
    |=> rdata_out == $past(wdata_in, 2)) else $error("mask write not read back");
  AST_UNMAPPED_ZERO: assert property (@(posedge clock_in) disable iff (srst_in)
    rd_in && addr_in > `PG_OFS_TERM_DISCH |=> rdata_out == 8'h00) else $error("unmapped read not zero");
  AST_DISCH: assert property (@(posedge clock_in) disable iff (srst_in)
    wr_in && addr_in == `PG_OFS_TERM_DISCH |=> termination_discharge_sel_out == $past(wdata_in[4]))
    else $error("discharge select wrong");
  AST_P3_ALL_MASKED: assert property (@(posedge clock_in) disable iff (srst_in)
    (&p3_mask) && pin_other_tree_good_in[3] |=> pg_output_pin_out[3]) else $error("pin3 not forced good");
  AST_P3_CTL5: assert property (@(posedge clock_in) disable iff (srst_in)
    !ctrl_in5_mask && !ctl_s[5] |=> !pg_output_pin_out[3]) else $error("input5 not in pin3 tree");
  AST_P3_TERM: assert property (@(posedge clock_in) disable iff (srst_in)
    !termination_reg_mask && !term_pg_s |=> !pg_output_pin_out[3]) else $error("termination pg ignored");
  AST_P3_SHARED: assert property (@(posedge clock_in) disable iff (srst_in)
    !shared_rail_mask && shared_rail_ff == pgood_tree_pkg::RAIL_LDO_A1 && !ldo_a1_a_pg_s
    |=> !pg_output_pin_out[3]) else $error("shared rail pg ignored");
  AST_P1_CONTROL_INPUT3: assert property (@(posedge clock_in) disable iff (srst_in)
    !pin1_in3_mask && !ctl_s[3] |=> !pg_output_pin_out[1]) else $error("input3 not in pin1 tree");
  AST_P2_MASKED: assert property (@(posedge clock_in) disable iff (srst_in)
    pin2_in6_mask && pin2_in3_mask && pin_other_tree_good_in[2] |=> pg_output_pin_out[2])
    else $error("pin2 masks not honoured");
  AST_P3_MASKED_BAD: assert property (@(posedge clock_in) disable iff (srst_in)
    (&p3_mask) && !ldoa3_pg_s && pin_other_tree_good_in[3] |=> pg_output_pin_out[3])
    else $error("masked source not ignored");

  // ----------------------------------------
  // register port checks
  // ----------------------------------------
  AST_RD_IDLE_ZERO: assert property (@(posedge clock_in) disable iff (srst_in)
    !rd_in |=> rdata_out == 8'h00) else $error("idle read data not zero");
  AST_RD_PIN3: assert property (@(posedge clock_in) disable iff (srst_in)
    rd_in && addr_in == `PG_OFS_PIN3_MASK2 |=> rdata_out == $past(pin3_tree_mask_second_ff))
    else $error("pin3 mask read wrong");
  AST_RD_CTRL: assert property (@(posedge clock_in) disable iff (srst_in)
    rd_in && addr_in == `PG_OFS_CTRL_MASKS |=> rdata_out == $past(ctrl_input_tree_masks_ff))
    else $error("cross mask read wrong");
  AST_RD_DISCH: assert property (@(posedge clock_in) disable iff (srst_in)
    rd_in && addr_in == `PG_OFS_TERM_DISCH |=> rdata_out == $past(termination_discharge_cfg_ff))
    else $error("discharge read wrong");
  AST_WR_PIN3: assert property (@(posedge clock_in) disable iff (srst_in)
    wr_in && addr_in == `PG_OFS_PIN3_MASK2 |=> pin3_tree_mask_second_ff == $past(wdata_in))
    else $error("pin3 mask write lost");
  AST_WR_CTRL: assert property (@(posedge clock_in) disable iff (srst_in)
    wr_in && addr_in == `PG_OFS_CTRL_MASKS |=> ctrl_input_tree_masks_ff == $past(wdata_in))
    else $error("cross mask write lost");
  AST_WR_DISCH: assert property (@(posedge clock_in) disable iff (srst_in)
    wr_in && addr_in == `PG_OFS_TERM_DISCH |=> termination_discharge_cfg_ff == $past(wdata_in))
    else $error("discharge write lost");
  AST_UNMAPPED_WR: assert property (@(posedge clock_in) disable iff (srst_in)
    wr_in && addr_in != `PG_OFS_PIN3_MASK2 && addr_in != `PG_OFS_CTRL_MASKS && addr_in != `PG_OFS_TERM_DISCH
    |=> $stable(pin3_tree_mask_second_ff) && $stable(ctrl_input_tree_masks_ff)
    && $stable(termination_discharge_cfg_ff)) else $error("unmapped write changed a register");

  // ----------------------------------------
  // reset checks
  // ----------------------------------------
  AST_RESET_LOAD: assert property (@(posedge clock_in)
    srst_in |=> pin3_tree_mask_second_ff == $past(otp_pin3_mask2_in)
    && ctrl_input_tree_masks_ff == $past(otp_ctrl_masks_in)
    && termination_discharge_cfg_ff == $past(otp_term_disch_in)) else $error("factory load wrong");
  AST_RESET_OUT: assert property (@(posedge clock_in)
    srst_in |=> pg_output_pin_out == 4'h0 && rdata_out == 8'h00) else $error("outputs not cleared in reset");
  AST_STRAP: assert property (@(posedge clock_in)
    srst_in |=> (shared_rail_ff == pgood_tree_pkg::RAIL_LDO_A1) == $past(otp_shared_is_ldo_in))
    else $error("shared rail variant not latched");

  // ----------------------------------------
  // tree checks
  // ----------------------------------------
  AST_STATUS_LAT: assert property (@(posedge clock_in) disable iff (srst_in)
    !ldo_a3_pg_in ##2 !ldo_a3_mask |=> !pg_output_pin_out[3]) else $error("low pg late at pin3");
  AST_P3_SHARED_SW: assert property (@(posedge clock_in) disable iff (srst_in)
    !shared_rail_mask && shared_rail_ff == pgood_tree_pkg::RAIL_SWITCH_B2 && !switch_b2_pg_s
    |=> !pg_output_pin_out[3]) else $error("switch rail pg ignored");
  AST_P3_CONTROL_INPUT6: assert property (@(posedge clock_in) disable iff (srst_in)
    !ctrl_input_tree_masks_ff[7] && !ctl_s[6] |=> !pg_output_pin_out[3]) else $error("input6 not in pin3 tree");
  AST_P4_CONTROL_INPUT6: assert property (@(posedge clock_in) disable iff (srst_in)
    !pin4_in6_mask && !ctl_s[6] |=> !pg_output_pin_out[4]) else $error("input6 not in pin4 tree");
  AST_P2_CONTROL_INPUT3: assert property (@(posedge clock_in) disable iff (srst_in)
    !pin2_in3_mask && !ctl_s[3] |=> !pg_output_pin_out[2]) else $error("input3 not in pin2 tree");
  AST_OTHER_GATE: assert property (@(posedge clock_in) disable iff (srst_in)
    !(|(pg_output_pin_out & ~$past(pin_other_tree_good_in)))) else $error("outer tree not honoured");
endmodule : pgood_tree_mask_regs

/* File: dv/pgood_tree_mask_regs_tb.sv */
`timescale 1ns/100ps
`include "pgood_tree_params.svh"
module pgood_tree_mask_regs_tb;
  localparam logic [7:0] OTP_AB = 8'h3c;
  localparam logic [7:0] OTP_AC = 8'h96;
  localparam logic [7:0] OTP_AD = `PG_OTP_TERM_DISCH;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic strap = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [10:0] src = 11'h7ff;
  logic [4:1] oth = 4'hf;
  logic [7:0] rdata;
  logic [4:1] pins;
  logic disch;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;

  pgood_tree_mask_regs pgood_tree_mask_regs_i (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .otp_pin3_mask2_in(OTP_AB),
    .otp_ctrl_masks_in(OTP_AC),
    .otp_term_disch_in(OTP_AD),
    .otp_shared_is_ldo_in(strap),
    .addr_in(addr),
    .wdata_in(wdata),
    .wr_in(wr),
    .rd_in(rd),
    .rdata_out(rdata),
    .ctrl_in_status_in(src[5:0]),
    .termination_regulator_pg_in(src[6]),
    .switch_b2_pg_in(src[7]),
    .ldo_a1_a_pg_in(src[8]),
    .switch_b1_pg_in(src[9]),
    .ldo_a3_pg_in(src[10]),
    .pin_other_tree_good_in(oth),
    .pg_output_pin_out(pins),
    .termination_discharge_sel_out(disch)
  );

  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  initial begin
    forever #5 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1 chk("rdata", rdata, exp);
  endtask : rd_chk

  task automatic do_reset(input logic s);
    @(posedge clock_in);
    srst_in <= 1'b1;
    strap <= s;
    repeat (12) @(posedge clock_in);
    srst_in <= 1'b0;
  endtask : do_reset

  function automatic logic [4:1] exp_pins(input logic [7:0] ab, input logic [7:0] ac);
    logic [7:0] g;
    g = {src[4], src[3], src[1], src[0], src[6], strap ? src[8] : src[7], src[9], src[10]};
    return {oth[4] & (ac[3] | src[5]) & (ac[2] | src[2]),
            oth[3] & (&(ab | g)) & (ac[7] | src[5]) & (ac[6] | src[2]),
            oth[2] & (ac[5] | src[5]) & (ac[4] | src[2]),
            oth[1] & (ac[1] | src[5]) & (ac[0] | src[2])};
  endfunction : exp_pins

  task automatic tree(input logic [7:0] ab, input logic [7:0] ac, input logic [10:0] s, input logic [4:1] o);
    bus(1'b1, 1'b0, `PG_OFS_PIN3_MASK2, ab);
    bus(1'b1, 1'b0, `PG_OFS_CTRL_MASKS, ac);
    src <= s;
    oth <= o;
    repeat (5) bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1 chk("pins", {4'h0, pins}, {4'h0, exp_pins(ab, ac)});
  endtask : tree

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    int idx [8];
    logic [10:0] base;
    logic [7:0] wv [3];
    idx = '{10, 9, 7, 6, 0, 1, 3, 4};
    wv = '{8'h5a, 8'ha5, OTP_AD ^ 8'h10};
    for (int st = 0; st < 2; st++) begin
      do_reset(st[0]);
      #1 chk("pins rst", {4'h0, pins}, 8'h00);
      rd_chk(`PG_OFS_PIN3_MASK2, OTP_AB);
      rd_chk(`PG_OFS_CTRL_MASKS, OTP_AC);
      rd_chk(`PG_OFS_TERM_DISCH, OTP_AD);
      chk("disch", {7'h00, disch}, {7'h00, OTP_AD[4]});
      idx[2] = st ? 8 : 7;
      base = st ? 11'h77f : 11'h6ff;
      for (int k = 0; k < 8; k++) begin
        tree(8'h00, 8'h00, base & ~(11'h001 << idx[k]), 4'hf);
        tree(8'h01 << k, 8'h00, base & ~(11'h001 << idx[k]), 4'hf);
      end
      for (int j = 0; j < 8; j++) begin
        tree(8'hff, ~(8'h01 << j), 11'h7db, 4'hf);
      end
      tree(8'hff, 8'hff, 11'h000, 4'hf);
      tree(8'hff, 8'hff, 11'h000, 4'ha);
    end
    for (int a = 0; a < 3; a++) begin
      bus(1'b1, 1'b0, 8'hab + a[7:0], wv[a]);
      rd_chk(8'hab + a[7:0], wv[a]);
    end
    for (int v = 0; v < 2; v++) begin
      // reserved bits rewritten with factory values
      bus(1'b1, 1'b0, `PG_OFS_TERM_DISCH, {OTP_AD[7:5], v[0], OTP_AD[3:0]});
      bus(1'b0, 1'b0, 8'h00, 8'h00);
      #1 chk("disch", {7'h00, disch}, {7'h00, v[0]});
      rd_chk(`PG_OFS_TERM_DISCH, {OTP_AD[7:5], v[0], OTP_AD[3:0]});
    end
    bus(1'b1, 1'b0, 8'hae, 8'hff);
    rd_chk(8'hae, 8'h00);
    rd_chk(`PG_OFS_PIN3_MASK2, 8'h5a);
    bus(1'b0, 1'b0, 8'h00, 8'h00);
    #1 chk("rdata idle", rdata, 8'h00);
    end_of_test();
  end
endmodule : pgood_tree_mask_regs_tb
